/* File: idt_pkg.sv */
// Contract
// - Every program memory location is taken as one 24-bit instruction word.
// - A single word splits into an 8-bit opcode that picks the type and operand fields.
// - Three opcodes span two words, and both are joined into one 48-bit encoding.
// - A word whose top eight bits are zero, met on its own, runs as a no-operation.
// - Plain words take one cycle, and a true condition or a program counter change adds one.
// - Always-branch, indirect call and jump, table access and returns take two or three cycles.
// - A performed skip takes two cycles over a one-word instruction and three over a two-word one.
// - Every two-word instruction takes exactly two cycles.
// - Working register word or byte forms carry a base, a moded source and a moded destination.
// - File register forms carry a file address and a destination of that file or register zero.
// - Bit forms name a register or file and take the bit from a literal or from a base register.
// - Literal arithmetic uses base and literal, with a destination only when it differs.
// - Multiply-accumulate forms name an accumulator, a multiplier pair, prefetches and write-back.
// - Other DSP forms name an accumulator, a moded operand and a register or literal shift.
// - Control forms carry a program address and, for table access, a mode field.
package idt_pkg;
	localparam int WORD_W  = 24;
	localparam int OPC_W   = 8;
	localparam int OPND_W  = 16;
	localparam int OPC_MSB = 23;
	localparam int OPC_LSB = 16;
	localparam int OPND_MSB = 15;
	localparam int CLS_MSB = 7;
	localparam int CLS_LSB = 5;

	typedef logic [OPC_W-1:0] idt_opc_t;
	typedef logic [WORD_W-1:0] idt_word_t;

	// Control opcodes; all live in the all-zero class
	localparam idt_opc_t OPC_NOP          = 8'h00;
	localparam idt_opc_t OPC_BRANCH_ALWAYS = 8'h01;
	localparam idt_opc_t OPC_BRANCH_COND  = 8'h02;
	localparam idt_opc_t OPC_CALL_IND     = 8'h03;
	localparam idt_opc_t OPC_GOTO_IND     = 8'h04;
	localparam idt_opc_t OPC_TABLE_RD     = 8'h05;
	localparam idt_opc_t OPC_TABLE_WR     = 8'h06;
	localparam idt_opc_t OPC_RETURN       = 8'h07;
	localparam idt_opc_t OPC_INT_RETURN   = 8'h08;
	localparam idt_opc_t OPC_SKIP         = 8'h09;
	localparam idt_opc_t OPC_CALL_FAR     = 8'h0A;
	localparam idt_opc_t OPC_GOTO_FAR     = 8'h0B;
	localparam idt_opc_t OPC_MOVE_DOUBLE  = 8'h0C;

	localparam logic [1:0] CYC_ONE   = 2'h1;
	localparam logic [1:0] CYC_TWO   = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [3:0] WORK_REGISTER_ZERO_ZERO = 4'h0;

	typedef enum logic [2:0] {
		CLS_CTRL = 3'b000, CLS_WORD_W = 3'b001, CLS_WORD_F = 3'b010, CLS_BIT = 3'b011,
		CLS_LIT  = 3'b100, CLS_MAC    = 3'b101, CLS_DSP    = 3'b110, CLS_MOVE = 3'b111
	} idt_class_e;

	typedef enum logic [1:0] {
		MOD_DIRECT = 2'b00, MOD_INDIRECT = 2'b01, MOD_POST_INC = 2'b10, MOD_PRE_DEC = 2'b11
	} idt_mod_e;

	typedef struct packed {
		logic [3:0] base; idt_mod_e dst_mode; logic [3:0] dst; idt_mod_e src_mode; logic [3:0] src;
	} idt_word_w_s;
	typedef struct packed {
		logic byte_mode; logic dest_is_work_register_zero; logic spare; logic [12:0] file_addr;
	} idt_word_f_s;
	typedef struct packed {
		logic bit_from_reg; logic use_file; logic [3:0] bit_sel; idt_mod_e src_mode;
		logic [3:0] src; logic [3:0] spare;
	} idt_bit_s;
	typedef struct packed {
		logic has_dest; logic [3:0] base; logic [4:0] literal; logic [3:0] dst; logic [1:0] spare;
	} idt_lit_s;
	typedef struct packed {
		logic acc_b; logic [2:0] mul_pair; logic [2:0] x_pref; logic [2:0] y_pref;
		logic [1:0] x_dst; logic [1:0] y_dst; logic [1:0] writeback;
	} idt_mac_s;
	typedef struct packed {
		logic acc_b; logic shift_from_reg; logic [5:0] shift; idt_mod_e mode;
		logic [3:0] reg_sel; logic [1:0] spare;
	} idt_dsp_s;
	typedef struct packed {
		logic [1:0] table_mode; logic [13:0] prog_addr;
	} idt_ctrl_s;

	typedef union packed {
		idt_word_w_s ww; idt_word_f_s wf; idt_bit_s bt; idt_lit_s lt;
		idt_mac_s mc; idt_dsp_s dp; idt_ctrl_s ct; logic [OPND_W-1:0] raw;
	} idt_opnd_u;

	// Resolved operand routing shared by all classes
	typedef struct packed {
		logic       dst_is_work_register_zero;
		logic [3:0] dst_reg;
		logic       bit_from_reg;
		logic       acc_b;
		logic       shift_from_reg;
		logic [1:0] table_mode;
		logic [13:0] prog_addr;
	} idt_route_s;

	typedef struct packed {
		logic       valid;
		logic       nop;
		logic       double_word;
		idt_class_e cls;
		idt_opc_t   opc;
		idt_opnd_u  opnd;
		idt_route_s route;
		idt_word_t  ext;
	} idt_exec_s;
endpackage : idt_pkg

/* File: idt_field_split.sv */
`timescale 1ns/1ps
module idt_field_split (
	input  wire idt_pkg::idt_word_t  word,
	output idt_pkg::idt_opc_t        opc,
	output idt_pkg::idt_class_e      cls,
	output idt_pkg::idt_opnd_u       opnd,
	output idt_pkg::idt_route_s      route,
	output logic                     is_double,
	output logic                     is_nop
);
	import idt_pkg::*;

	assign opc  = word[OPC_MSB:OPC_LSB];
	assign cls  = idt_class_e'(word[OPC_LSB+CLS_LSB +: $bits(idt_class_e)]);
	assign opnd = idt_opnd_u'(word[OPND_MSB:0]);
	assign is_nop    = (opc == OPC_NOP);
	assign is_double = (opc == OPC_CALL_FAR) || (opc == OPC_GOTO_FAR) || (opc == OPC_MOVE_DOUBLE);

	always_comb begin
		route = '0;
		unique case (cls)
			CLS_WORD_W: begin
				route.dst_reg = opnd.ww.dst;
			end
			CLS_WORD_F: begin
				route.dst_is_work_register_zero = opnd.wf.dest_is_work_register_zero;
				route.dst_reg     = WORK_REGISTER_ZERO_ZERO;
			end
			CLS_BIT: begin
				route.bit_from_reg = opnd.bt.bit_from_reg;
				route.dst_reg      = opnd.bt.src;
			end
			CLS_LIT, CLS_MOVE: begin
				// Result falls back on the base when no destination is coded
				route.dst_reg = opnd.lt.has_dest ? opnd.lt.dst : opnd.lt.base;
			end
			CLS_MAC: begin
				route.acc_b = opnd.mc.acc_b;
			end
			CLS_DSP: begin
				route.acc_b          = opnd.dp.acc_b;
				route.shift_from_reg = opnd.dp.shift_from_reg;
				route.dst_reg        = opnd.dp.reg_sel;
			end
			CLS_CTRL: begin
				route.prog_addr  = opnd.ct.prog_addr;
				route.table_mode = (opc == OPC_TABLE_RD || opc == OPC_TABLE_WR) ?
					opnd.ct.table_mode : 2'h0;
			end
		endcase
	end
endmodule : idt_field_split

/* File: idt_decoder.sv */
`timescale 1ns/1ps
module idt_decoder #(
	parameter logic [1:0] CYC_BRANCH   = idt_pkg::CYC_TWO,
	parameter logic [1:0] CYC_INDIRECT = idt_pkg::CYC_TWO,
	parameter logic [1:0] CYC_TABLE    = idt_pkg::CYC_TWO,
	parameter logic [1:0] CYC_RETURN   = idt_pkg::CYC_THREE
) (
	input  wire logic               mclk,
	input  wire logic               reset,
	input  wire logic               fetch_valid,
	input  wire idt_pkg::idt_word_t fetch_word,
	input  wire logic               cond_true,
	output logic                    fetch_ready,
	output idt_pkg::idt_exec_s      exec
);
	import idt_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_SECOND = 2'b01,
		ST_STALL  = 2'b10
	} idt_state_e;

	idt_state_e state;
	idt_state_e next_state;
	idt_word_t  held;
	idt_word_t  next_held;
	logic [1:0] stall;
	logic [1:0] next_stall;
	logic       flush;
	logic       next_flush;
	idt_exec_s  next_exec;
	logic [1:0] cyc;

	idt_opc_t   d_opc;
	idt_class_e d_cls;
	idt_opnd_u  d_opnd;
	idt_route_s d_route;
	logic       d_double;
	logic       d_nop;
	logic       take;

	idt_field_split u_split (
		.word      (fetch_word),
		.opc       (d_opc),
		.cls       (d_cls),
		.opnd      (d_opnd),
		.route     (d_route),
		.is_double (d_double),
		.is_nop    (d_nop)
	);

	// Fetch is held off while filler cycles run
	assign fetch_ready = (state != ST_STALL);
	assign take        = fetch_valid && fetch_ready;

	always_comb begin
		unique case (d_opc)
			OPC_BRANCH_ALWAYS:             cyc = CYC_BRANCH;
			OPC_CALL_IND, OPC_GOTO_IND:    cyc = CYC_INDIRECT;
			OPC_TABLE_RD, OPC_TABLE_WR:    cyc = CYC_TABLE;
			OPC_RETURN, OPC_INT_RETURN:    cyc = CYC_RETURN;
			OPC_BRANCH_COND:               cyc = cond_true ? CYC_TWO : CYC_ONE;
			default:                       cyc = CYC_ONE;
		endcase
	end

	always_comb begin
		next_state = state;
		next_held  = held;
		next_stall = stall;
		next_flush = flush;
		next_exec  = '0;
		unique case (state)
			ST_RUN: begin
				if (take && flush) begin
					// Skipped word; a skipped opener drags its second word along
					next_exec.nop = 1'b1;
					next_flush    = d_double;
				end else if (take && d_double) begin
					next_held  = fetch_word;
					next_state = ST_SECOND;
				end else if (take && d_nop) begin
					next_exec.nop = 1'b1;
				end else if (take) begin
					next_exec.valid = 1'b1;
					next_exec.cls   = d_cls;
					next_exec.opc   = d_opc;
					next_exec.opnd  = d_opnd;
					next_exec.route = d_route;
					if (cyc != CYC_ONE) begin
						next_stall = cyc - CYC_ONE;
						next_state = ST_STALL;
					end
					next_flush = (d_opc == OPC_SKIP) && cond_true;
				end
			end
			ST_SECOND: begin
				// Opener cycle plus this one make the two cycles
				if (take) begin
					next_exec.valid       = 1'b1;
					next_exec.double_word = 1'b1;
					next_exec.cls         = idt_class_e'(held[OPC_LSB+CLS_LSB +: 3]);
					next_exec.opc         = held[OPC_MSB:OPC_LSB];
					next_exec.opnd        = idt_opnd_u'(held[OPND_MSB:0]);
					next_exec.route.prog_addr = next_exec.opnd.ct.prog_addr;
					next_exec.ext         = fetch_word;
					next_state            = ST_RUN;
				end
			end
			ST_STALL: begin
				next_exec.nop = 1'b1;
				next_stall    = stall - CYC_ONE;
				if (stall == CYC_ONE) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= ST_RUN;
			held  <= '0;
			stall <= '0;
			flush <= 1'b0;
			exec  <= '0;
		end else begin
			state <= next_state;
			held  <= next_held;
			stall <= next_stall;
			flush <= next_flush;
			exec  <= next_exec;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	stall_blocks_fetch_a: assert property (
		(state == ST_STALL) |-> !fetch_ready ##1 (exec.nop && !exec.valid)
	) else $error("filler cycle not run as no-operation");

	branch_two_cycles_a: assert property (
		(take && state == ST_RUN && !flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_BRANCH_ALWAYS)
		|=> exec.valid ##1 (exec.nop && state == ST_RUN)
	) else $error("always-branch did not take two cycles");

	return_three_cycles_a: assert property (
		(take && state == ST_RUN && !flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_RETURN)
		|=> exec.valid ##1 exec.nop[*2] ##0 (state == ST_RUN)
	) else $error("return did not take three cycles");

	cond_false_single_a: assert property (
		(take && state == ST_RUN && !flush && !cond_true
			&& fetch_word[OPC_MSB:OPC_LSB] == OPC_BRANCH_COND)
		|=> (exec.valid && fetch_ready)
	) else $error("untaken branch stalled");

	skip_drops_single_a: assert property (
		(take && state == ST_RUN && flush && fetch_word[OPC_MSB:OPC_LSB] != OPC_CALL_FAR
			&& fetch_word[OPC_MSB:OPC_LSB] != OPC_GOTO_FAR
			&& fetch_word[OPC_MSB:OPC_LSB] != OPC_MOVE_DOUBLE)
		|=> (exec.nop && !exec.valid && !flush)
	) else $error("skipped one-word instruction not dropped");

	skip_drops_double_a: assert property (
		(take && state == ST_RUN && flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_GOTO_FAR)
		|=> (exec.nop && flush && state == ST_RUN)
	) else $error("skipped two-word instruction lost its second word");

	double_joins_words_a: assert property (
		(take && state == ST_SECOND)
		|=> (exec.valid && exec.double_word && exec.ext == $past(fetch_word)
			&& exec.opc == $past(held[OPC_MSB:OPC_LSB]))
	) else $error("two-word instruction not assembled");

	opener_waits_a: assert property (
		(take && state == ST_RUN && !flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_CALL_FAR)
		|=> (state == ST_SECOND && !exec.valid && fetch_ready)
	) else $error("opener did not wait for second word");

	stray_second_nop_a: assert property (
		(take && state == ST_RUN && !flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_NOP)
		|=> (exec.nop && !exec.valid)
	) else $error("zero-topped word did not run as no-operation");

	opcode_field_a: assert property (
		(take && state == ST_RUN && !flush) |=> (!exec.valid
			|| exec.opc == $past(fetch_word[OPC_MSB:OPC_LSB]))
	) else $error("opcode field mismatch");

	cond_true_two_a: assert property (
		(take && state == ST_RUN && !flush && cond_true
			&& fetch_word[OPC_MSB:OPC_LSB] == OPC_BRANCH_COND)
		|=> exec.valid ##1 (exec.nop && state == ST_RUN)
	) else $error("taken branch did not take two cycles");

	int_return_three_a: assert property (
		(take && state == ST_RUN && !flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_INT_RETURN)
		|=> exec.valid ##1 exec.nop[*2] ##0 (state == ST_RUN)
	) else $error("interrupt return did not take three cycles");

	table_mode_kept_a: assert property (
		(take && state == ST_RUN && !flush && fetch_word[OPC_MSB:OPC_LSB] == OPC_TABLE_WR)
		|=> (exec.route.table_mode == $past(fetch_word[OPND_MSB -: $bits(exec.route.table_mode)]))
	) else $error("table access mode lost");

	file_dest_route_a: assert property (
		(take && state == ST_RUN && !flush
			&& fetch_word[OPC_LSB+CLS_LSB +: $bits(idt_class_e)] == CLS_WORD_F)
		|=> (exec.route.dst_reg == WORK_REGISTER_ZERO_ZERO
			&& exec.route.dst_is_work_register_zero == $past(d_opnd.wf.dest_is_work_register_zero))
	) else $error("file destination selector lost");
endmodule : idt_decoder

/* File: idt_prog_mem.sv */
`timescale 1ns/1ps
module idt_prog_mem (
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          push,
	input  wire logic [24:0]   push_data,
	input  wire logic          stall,
	input  wire logic          fetch_ready,
	output logic               fetch_valid = 1'h0,
	output idt_pkg::idt_word_t fetch_word = '0,
	output logic               cond_true = 1'h0
);
	import idt_pkg::*;
	logic [24:0] q[$];
	always @(posedge mclk) begin
		if (push)
			q.push_back(push_data);
		if (reset)
			fetch_valid <= 1'h0;
		else if (!fetch_valid || fetch_ready) begin // Offer held until taken
			fetch_valid <= q.size() > 0 && !stall;
			if (q.size() > 0 && !stall)
				{cond_true, fetch_word} <= q.pop_front();
			else
				{cond_true, fetch_word} <= ~{cond_true, fetch_word}; // No stale data when idle
		end
	end
endmodule : idt_prog_mem

/* File: instruction_decode_timing_tb.sv */
`timescale 1ns/1ps
module instruction_decode_timing_tb;
	import idt_pkg::*;
	logic        mclk;
	logic        reset;
	logic        push;
	logic [24:0] push_data;
	logic        stall;
	logic        fetch_valid;
	idt_word_t   fetch_word;
	logic        cond_true;
	logic        fetch_ready;
	idt_exec_s   exec;
	int          mismatches;
	int          total_checks;
	int          cycles;
	logic [31:0] rng;
	logic [51:0] expq[$];
	logic [51:0] want;
	logic [50:0] got;
	logic        skip;
	logic        opening;
	logic [7:0]  open_opc;
	logic [15:0] open_opnd;
	localparam logic [24:0] CORNER [18] = '{25'h0_001234, 25'h0_010010, 25'h0_070000,
		25'h0_080000, 25'h1_020000, 25'h0_020000, 25'h1_090000, 25'h0_0A1111, 25'h0_002222,
		25'h1_090000, 25'h0_213333, 25'h0_0B4444, 25'h0_005555, 25'h0_0C6666, 25'h0_007777,
		25'h0_05C123, 25'h0_064001, 25'h0_404ABC};

	idt_prog_mem mem (.mclk(mclk), .reset(reset), .push(push), .push_data(push_data),
		.stall(stall), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .cond_true(cond_true));
	idt_decoder dut (.mclk(mclk), .reset(reset), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .cond_true(cond_true), .fetch_ready(fetch_ready), .exec(exec));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	function automatic int fillers(input logic [7:0] op, input logic c);
		case (op)
			OPC_BRANCH_ALWAYS, OPC_CALL_IND, OPC_GOTO_IND, OPC_TABLE_RD, OPC_TABLE_WR: return 1;
			OPC_RETURN, OPC_INT_RETURN: return 2;
			OPC_BRANCH_COND: return c ? 1 : 0;
			default: return 0;
		endcase
	endfunction : fillers

	// Routing the decoder must resolve, from the class and the operand layout
	function automatic idt_route_s route_want(input logic [7:0] op, input logic [15:0] o);
		idt_route_s r;
		r = '0;
		case (op[7:5])
			3'h0: begin
				r.prog_addr = o[13:0];
				if (op inside {OPC_TABLE_RD, OPC_TABLE_WR})
					r.table_mode = o[15:14];
			end
			3'h1: r.dst_reg = o[9:6];
			3'h2: r.dst_is_work_register_zero = o[14];
			3'h3: begin
				r.bit_from_reg = o[15];
				r.dst_reg = o[7:4];
			end
			3'h4, 3'h7: r.dst_reg = o[15] ? o[5:2] : o[14:11];
			3'h5: r.acc_b = o[15];
			default: begin
				r.acc_b = o[15];
				r.shift_from_reg = o[14];
				r.dst_reg = o[5:2];
			end
		endcase
		return r;
	endfunction : route_want

	task automatic check(input logic [51:0] seen, input logic [51:0] exp_v);
		total_checks++;
		if (seen !== exp_v) begin
			mismatches++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp_v);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// Hands one word to memory and predicts what the decoder must issue
	task automatic feed(input logic c, input idt_word_t w);
		logic [7:0] op;
		op = w[23:16];
		@(posedge mclk);
		push <= 1'h1;
		push_data <= {c, w};
		if (opening) begin
			expq.push_back({4'h5, open_opc, open_opnd, w});
			opening = 1'h0;
		end else if (skip) begin
			expq.push_back(52'h2 << 48);
			skip = op inside {OPC_CALL_FAR, OPC_GOTO_FAR, OPC_MOVE_DOUBLE};
		end else if (op == OPC_NOP) begin
			expq.push_back(52'h2 << 48);
		end else if (op inside {OPC_CALL_FAR, OPC_GOTO_FAR, OPC_MOVE_DOUBLE}) begin
			opening = 1'h1;
			open_opc = op;
			open_opnd = w[15:0];
		end else begin
			expq.push_back({4'h4, op, w[15:0], 24'h0});
			repeat (fillers(op, c)) expq.push_back(52'hA << 48);
			skip = op == OPC_SKIP && c;
		end
	endtask : feed

	task automatic drain(input string name);
		stall <= 1'h0;
		@(posedge mclk);
		push <= 1'h0;
		for (int i = 0; i < 400 && expq.size() > 0; i++)
			@(posedge mclk);
		repeat (4) @(posedge mclk);
		check(expq.size(), 0);
		$display("test %s done", name);
	endtask : drain

	always @(negedge mclk) begin
		if (!reset && (exec.valid === 1'h1 || exec.nop === 1'h1)) begin
			want = expq.size() > 0 ? expq.pop_front() : '1;
			got = {exec.valid, exec.nop, exec.double_word, exec.opc, exec.opnd, exec.ext};
			if (want[49]) begin
				check(got[50:49], want[50:49]);
			end else begin
				check(got, want[50:0]);
				check(exec.cls, want[47:45]);
				if (want[47:45] == 3'h2)
					check(exec.route.dst_is_work_register_zero, want[38]);
				if (want[47:40] inside {OPC_TABLE_RD, OPC_TABLE_WR})
					check(exec.route.table_mode, want[39:38]);
				check(exec.route, route_want(want[47:40], want[39:24]));
			end
		end
		if (!reset)
			check(fetch_ready, !(expq.size() > 0 && expq[0][51]));
	end

	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin // Far beyond the several hundred cycles needed
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		logic [7:0] op;
		{reset, push, push_data, stall, skip, opening} = {1'h1, 29'h0};
		{mismatches, total_checks, cycles} = '0;
		rng = 32'h34;
		repeat (12) @(posedge mclk);
		reset <= 1'h0;
		foreach (CORNER[i])
			feed(CORNER[i][24], CORNER[i][23:0]);
		drain("corner");
		for (int i = 0; i < 300; i++) begin
			rng = xs(rng);
			op = rng[3] ? {3'(rng[6:4] % 7 + 1), rng[12:8]} : 8'(rng[11:8] % 13);
			stall <= rng[30] & rng[29];
			feed(rng[20], {op, rng[31:16]});
			if (op inside {OPC_CALL_FAR, OPC_GOTO_FAR, OPC_MOVE_DOUBLE})
				feed(rng[21], {8'h00, rng[15:0]});
		end
		drain("random");
		print_verdict();
	end
endmodule : instruction_decode_timing_tb
